// *** rtl/adc_regs_pkg.sv ***
// adc_regs_pkg: register map, field layout, reset values and shared types of the converter control bank.
// assumes a single 10 MHz clock domain; the serial port pins are sampled as synchronous inputs.
//
// Summary of operation
// - channel-index low bits pick which data channel takes per-channel writes
// - writes act at once, except override register contents which stay pending
// - pending override applies only when transfer bit 0 is written one
// - power mode 00: datapath clocks, datapath and outputs run normally
// - power mode 01: clocks gated, datapath held in reset, outputs off
// - power mode 10: clocks and outputs off, no datapath reset
// - power mode 11: datapath and outputs reset, serial port untouched
// - serial port reset only by power-on reset, never by a register
// - enhancement bit 2 enables first-stage chopping
// - output-mode bit 6 selects reduced range, clear gives standard range
// - output-mode bit 2 inverts every bit of the serial data stream
// - output-mode bit 0 resets to one, two's complement; clear gives offset binary
// - output-adjust bits 5:4 choose the internal termination resistor
// - output-adjust bit 0 doubles clock-output drive once clock channel is selected
// - termination setting prevails over doubled clock-output drive
// - phase bits 6:4 delay sampling 0 to 7 cycles, only with divider on
// - phase bits 3:0 shift data clock in 60 degree steps, codes 0 to 11
// - override low three bits cap sample-rate capability, not actual rate
// - user I/O two bit 0 disconnects the serial data pin pull-down
// - user I/O three bit 3 powers down the common-mode generator
// - serial output control resets to 0x32

package adc_regs_pkg;
  // register addresses on the 13-bit serial port address space
  localparam logic [12:0] A_CHAN_IDX = 13'h005;
  localparam logic [12:0] A_PMODE = 13'h008;
  localparam logic [12:0] A_ENH = 13'h00c;
  localparam logic [12:0] A_OMODE = 13'h014;
  localparam logic [12:0] A_OADJ = 13'h015;
  localparam logic [12:0] A_OPHASE = 13'h016;
  localparam logic [12:0] A_SERCTL = 13'h021;
  localparam logic [12:0] A_XFER = 13'h0ff;
  localparam logic [12:0] A_OVR = 13'h100;
  localparam logic [12:0] A_UIO2 = 13'h101;
  localparam logic [12:0] A_UIO3 = 13'h102;

  // implemented bits of each register; the rest read zero
  localparam logic [7:0] M_CHAN_IDX = 8'h33;
  localparam logic [7:0] M_ENH = 8'h04;
  localparam logic [7:0] M_OMODE = 8'h45;
  localparam logic [7:0] M_OADJ_LANE = 8'h30;
  localparam logic [7:0] M_OADJ_CLK = 8'h31;
  localparam logic [7:0] M_OPHASE = 8'h7f;
  localparam logic [7:0] M_OVR = 8'h77;
  localparam logic [7:0] M_UIO2 = 8'h01;
  localparam logic [7:0] M_UIO3 = 8'h08;

  // reset values
  localparam logic [7:0] R_CHAN_IDX = 8'h33;
  localparam logic [7:0] R_OMODE = 8'h01;
  localparam logic [7:0] R_OPHASE = 8'h03;
  localparam logic [7:0] R_SERCTL = 8'h32;
  localparam logic [7:0] R_ZERO = 8'h00;

  // field positions
  localparam int B_CHOP = 2;
  localparam int B_RANGE = 6;
  localparam int B_INVERT = 2;
  localparam int B_FORMAT = 0;
  localparam int B_DRIVE = 0;
  localparam int B_COMMIT = 0;
  localparam int B_PD_OFF = 0;
  localparam int B_CM_PD = 3;
  localparam int B_OVR_EN = 6;
  localparam int F_TERM = 4;
  localparam int F_IPH = 4;
  localparam int F_RES = 4;
  localparam int F_CLKSEL = 4;
  localparam logic [3:0] DCO_PH_MAX = 4'hb;

  // power modes
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_POWERDOWN = 2'h1;
  localparam logic [1:0] PM_STANDBY = 2'h2;
  localparam logic [1:0] PM_DIGRESET = 2'h3;

  // serial frame: 16 instruction bits, 8 data bits per byte
  localparam logic [3:0] LAST_INSTR_BIT = 4'hf;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_INSTR = 4'b0010,
    PH_DATA = 4'b0100,
    PH_DONE = 4'b1000
  } spi_ph_t;

  typedef struct packed {
    logic reduced_range;
    logic invert;
    logic twos_comp;
    logic [1:0] term;
  } lane_cfg_t;

  typedef struct packed {
    logic enable;
    logic [1:0] resolution;
    logic [2:0] rate_cap;
  } ovr_t;
endpackage

// *** rtl/chan_regs.sv ***
// chan_regs: one data channel's local copy of the output-mode and output-adjust registers.
// assumes write strobes are already qualified by the channel selection.
`timescale 1ns/100ps
module chan_regs (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // write side
  input wire logic wr_mode,
  input wire logic wr_adj,
  input wire logic [7:0] wdata,
  // stored values and decoded lane settings
  output logic [7:0] mode_q,
  output logic [7:0] adj_q,
  output adc_regs_pkg::lane_cfg_t cfg
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] adj;
  } chst_t;

  chst_t st_q;
  chst_t st_d;

  // masked stores keep unassigned bits at zero
  always_comb begin
    st_d = st_q;
    if (wr_mode) st_d.mode = wdata & adc_regs_pkg::M_OMODE;
    if (wr_adj) st_d.adj = wdata & adc_regs_pkg::M_OADJ_LANE;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{mode: adc_regs_pkg::R_OMODE, adj: adc_regs_pkg::R_ZERO};
    end else begin
      st_q <= st_d;
    end
  end

  assign mode_q = st_q.mode;
  assign adj_q = st_q.adj;
  assign cfg.reduced_range = st_q.mode[adc_regs_pkg::B_RANGE];
  assign cfg.invert = st_q.mode[adc_regs_pkg::B_INVERT];
  assign cfg.twos_comp = st_q.mode[adc_regs_pkg::B_FORMAT];
  assign cfg.term = st_q.adj[adc_regs_pkg::F_TERM +: 2];

  AST_MODE_MASKED: assert property (@(posedge clk) disable iff (!resetn)
    wr_mode |=> mode_q == ($past(wdata) & adc_regs_pkg::M_OMODE))
    else $error("output mode store lost or kept reserved bits");
endmodule // chan_regs

// *** rtl/override_stage.sv ***
// override_stage: pending and active copies of the resolution/sample-rate override.
// assumes one write strobe at a time; pending and commit never coincide.
`timescale 1ns/100ps
module override_stage (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // write side
  input wire logic wr_pend,
  input wire logic wr_xfer,
  input wire logic [7:0] wdata,
  // register view and applied settings
  output logic [7:0] pend_q,
  output adc_regs_pkg::ovr_t ovr
);
  typedef struct packed {
    logic [7:0] pend;
    logic [7:0] act;
  } ovst_t;

  ovst_t st_q;
  ovst_t st_d;
  logic commit;

  // the transfer bit is a trigger only; nothing of it is stored
  assign commit = wr_xfer & wdata[adc_regs_pkg::B_COMMIT];

  always_comb begin
    st_d = st_q;
    if (wr_pend) st_d.pend = wdata & adc_regs_pkg::M_OVR;
    if (commit) st_d.act = st_q.pend;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{pend: adc_regs_pkg::R_ZERO, act: adc_regs_pkg::R_ZERO};
    end else begin
      st_q <= st_d;
    end
  end

  assign pend_q = st_q.pend;
  assign ovr.enable = st_q.act[adc_regs_pkg::B_OVR_EN];
  assign ovr.resolution = st_q.act[adc_regs_pkg::F_RES +: 2];
  assign ovr.rate_cap = st_q.act[2:0];

  AST_OVR_HELD: assert property (@(posedge clk) disable iff (!resetn)
    (wr_pend && !commit) |=> ovr == $past(ovr))
    else $error("override applied without transfer");

  AST_OVR_COMMIT: assert property (@(posedge clk) disable iff (!resetn)
    commit |=> st_q.act == $past(st_q.pend))
    else $error("transfer did not apply pending override");
endmodule // override_stage

// *** rtl/adc_ctrl_bank.sv ***
// adc_ctrl_bank: serial port slave and control register bank of a dual-channel converter.
// assumes SCLK, CSB_N and SDIO_I are synchronous to CLK and SCLK runs well below CLK/2;
// RESETN is the power-on reset and is the only thing that resets the serial port.
`timescale 1ns/100ps
module adc_ctrl_bank #(
  parameter int NUM_CH = 2
) (
  // clock and power-on reset
  input wire logic CLK,
  input wire logic RESETN,
  // serial port pins
  input wire logic SCLK,
  input wire logic CSB_N,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE,
  // clock divider status from outside the bank
  input wire logic CLOCK_DIVIDER_ON,
  // digital datapath control
  output logic DP_CLK_EN,
  output logic DP_RESET,
  output logic OUT_EN,
  output logic CHOP_EN,
  // data lane settings, one entry per channel
  output adc_regs_pkg::lane_cfg_t [NUM_CH-1:0] LANE_CFG,
  // frame and data clock output settings
  output logic [1:0] CLK_TERM,
  output logic CLK_DRIVE_2X,
  output logic [2:0] INPUT_PHASE,
  output logic [3:0] DCO_PHASE,
  output logic [7:0] SERIAL_CTL,
  // applied override and pin controls
  output adc_regs_pkg::ovr_t OVERRIDE,
  output logic SDIO_PD_OFF,
  output logic CM_GEN_PD
);
  // the channel index only has two data-channel select bits
  if (NUM_CH < 1 || NUM_CH > 2) begin : g_bad_ch
    $error("NUM_CH must be 1 or 2");
  end

  typedef struct packed {
    adc_regs_pkg::spi_ph_t ph;
    logic sclk_p;
    logic [3:0] cnt;
    logic [14:0] sh;
    logic rd;
    logic [1:0] left;
    logic [12:0] addr;
    logic [7:0] rbyte;
    logic sdo;
    logic [7:0] idx;
    logic [1:0] pm;
    logic [7:0] enh;
    logic [7:0] clk_adj;
    logic [7:0] oph;
    logic [7:0] ser;
    logic [7:0] uio2;
    logic [7:0] uio3;
  } st_t;

  localparam st_t ST_RST = '{
    ph: adc_regs_pkg::PH_IDLE,
    sclk_p: 1'b0,
    cnt: 4'h0,
    sh: 15'h0000,
    rd: 1'b0,
    left: 2'h0,
    addr: 13'h0000,
    rbyte: 8'h00,
    sdo: 1'b0,
    idx: adc_regs_pkg::R_CHAN_IDX,
    pm: adc_regs_pkg::PM_NORMAL,
    enh: adc_regs_pkg::R_ZERO,
    clk_adj: adc_regs_pkg::R_ZERO,
    oph: adc_regs_pkg::R_OPHASE,
    ser: adc_regs_pkg::R_SERCTL,
    uio2: adc_regs_pkg::R_ZERO,
    uio3: adc_regs_pkg::R_ZERO
  };

  st_t st_q;
  st_t st_d;
  logic rise;
  logic fall;
  logic wr_go;
  logic [7:0] wdata;
  logic [12:0] next_addr;
  logic [NUM_CH-1:0] wr_mode;
  logic [NUM_CH-1:0] wr_adj;
  logic [7:0] ch_mode [NUM_CH];
  logic [7:0] ch_adj [NUM_CH];
  logic [7:0] ovr_pend;
  int rsel;

  // edge detect on the sampled serial clock; only meaningful while selected
  assign rise = SCLK & ~st_q.sclk_p & ~CSB_N;
  assign fall = ~SCLK & st_q.sclk_p & ~CSB_N;
  assign wdata = {st_q.sh[6:0], SDIO_I};
  assign next_addr = st_q.addr + 13'h0001;
  // reads of channel registers come from the lowest selected data channel
  assign rsel = (st_q.idx[0] || NUM_CH == 1) ? 0 : 1;

  // read value for any address; unmapped addresses read zero
  function automatic logic [7:0] rd_val(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == adc_regs_pkg::A_CHAN_IDX) begin
      v = st_q.idx;
    end else if (a == adc_regs_pkg::A_PMODE) begin
      v = {6'h00, st_q.pm};
    end else if (a == adc_regs_pkg::A_ENH) begin
      v = st_q.enh;
    end else if (a == adc_regs_pkg::A_OMODE) begin
      v = ch_mode[rsel];
    end else if (a == adc_regs_pkg::A_OADJ) begin
      // with only clock channels selected the clock copy is shown
      v = (st_q.idx[1:0] != 2'h0) ? ch_adj[rsel] : st_q.clk_adj;
    end else if (a == adc_regs_pkg::A_OPHASE) begin
      v = st_q.oph;
    end else if (a == adc_regs_pkg::A_SERCTL) begin
      v = st_q.ser;
    end else if (a == adc_regs_pkg::A_OVR) begin
      v = ovr_pend;
    end else if (a == adc_regs_pkg::A_UIO2) begin
      v = st_q.uio2;
    end else if (a == adc_regs_pkg::A_UIO3) begin
      v = st_q.uio3;
    end
    return v;
  endfunction

  // serial frame engine and global register writes; no register field reaches this path's reset
  always_comb begin
    st_d = st_q;
    st_d.sclk_p = SCLK;
    wr_go = 1'b0;
    if (CSB_N) begin
      st_d.ph = adc_regs_pkg::PH_IDLE;
      st_d.cnt = 4'h0;
    end else begin
      case (st_q.ph)
        adc_regs_pkg::PH_IDLE, adc_regs_pkg::PH_INSTR: begin
          st_d.ph = adc_regs_pkg::PH_INSTR;
          if (rise) begin
            st_d.sh = {st_q.sh[13:0], SDIO_I};
            st_d.cnt = st_q.cnt + 4'h1;
            if (st_q.cnt == adc_regs_pkg::LAST_INSTR_BIT) begin
              st_d.ph = adc_regs_pkg::PH_DATA;
              st_d.cnt = 4'h0;
              st_d.rd = st_q.sh[14];
              st_d.left = st_q.sh[13:12];
              st_d.addr = {st_q.sh[11:0], SDIO_I};
              st_d.rbyte = rd_val({st_q.sh[11:0], SDIO_I});
            end
          end
        end
        adc_regs_pkg::PH_DATA: begin
          if (rise) begin
            st_d.sh = {st_q.sh[13:0], SDIO_I};
            st_d.cnt = st_q.cnt + 4'h1;
            if (st_q.cnt == adc_regs_pkg::LAST_DATA_BIT) begin
              wr_go = ~st_q.rd;
              st_d.cnt = 4'h0;
              st_d.addr = next_addr;
              st_d.rbyte = rd_val(next_addr);
              // length code 3 streams until deselect, otherwise count bytes down
              if (st_q.left != adc_regs_pkg::LEN_STREAM) begin
                if (st_q.left == 2'h0) st_d.ph = adc_regs_pkg::PH_DONE;
                else st_d.left = st_q.left - 2'h1;
              end
            end
          end
          // read data changes on the falling edge so the host samples it on the rise
          if (fall && st_q.rd) st_d.sdo = st_q.rbyte[3'(adc_regs_pkg::LAST_DATA_BIT - st_q.cnt)];
        end
        adc_regs_pkg::PH_DONE: begin
          st_d.ph = adc_regs_pkg::PH_DONE; // extra clocks ignored until deselect
        end
        default: begin
          st_d.ph = adc_regs_pkg::PH_IDLE;
        end
      endcase
    end

    // global register writes take effect at once
    if (wr_go) begin
      if (st_q.addr == adc_regs_pkg::A_CHAN_IDX) begin
        st_d.idx = wdata & adc_regs_pkg::M_CHAN_IDX;
      end else if (st_q.addr == adc_regs_pkg::A_PMODE) begin
        st_d.pm = wdata[1:0];
      end else if (st_q.addr == adc_regs_pkg::A_ENH) begin
        st_d.enh = wdata & adc_regs_pkg::M_ENH;
      end else if (st_q.addr == adc_regs_pkg::A_OADJ) begin
        // the clock copy is written only when a clock channel is selected
        if (st_q.idx[adc_regs_pkg::F_CLKSEL +: 2] != 2'h0) st_d.clk_adj = wdata & adc_regs_pkg::M_OADJ_CLK;
      end else if (st_q.addr == adc_regs_pkg::A_OPHASE) begin
        st_d.oph = wdata & adc_regs_pkg::M_OPHASE;
        // codes above 660 degrees are not defined, the old shift is kept
        if (wdata[3:0] > adc_regs_pkg::DCO_PH_MAX) st_d.oph[3:0] = st_q.oph[3:0];
      end else if (st_q.addr == adc_regs_pkg::A_SERCTL) begin
        st_d.ser = wdata;
      end else if (st_q.addr == adc_regs_pkg::A_UIO2) begin
        st_d.uio2 = wdata & adc_regs_pkg::M_UIO2;
      end else if (st_q.addr == adc_regs_pkg::A_UIO3) begin
        st_d.uio3 = wdata & adc_regs_pkg::M_UIO3;
      end
    end
  end

  // the only reset of the serial port and the registers is the power-on reset
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // per-channel registers follow the channel selection
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign wr_mode[i] = wr_go & (st_q.addr == adc_regs_pkg::A_OMODE) & st_q.idx[i];
    assign wr_adj[i] = wr_go & (st_q.addr == adc_regs_pkg::A_OADJ) & st_q.idx[i];
    chan_regs u_chan (
      .clk(CLK),
      .resetn(RESETN),
      .wr_mode(wr_mode[i]),
      .wr_adj(wr_adj[i]),
      .wdata(wdata),
      .mode_q(ch_mode[i]),
      .adj_q(ch_adj[i]),
      .cfg(LANE_CFG[i])
    );
  end

  // override contents wait for the transfer bit
  override_stage u_ovr (
    .clk(CLK),
    .resetn(RESETN),
    .wr_pend(wr_go & (st_q.addr == adc_regs_pkg::A_OVR)),
    .wr_xfer(wr_go & (st_q.addr == adc_regs_pkg::A_XFER)),
    .wdata(wdata),
    .pend_q(ovr_pend),
    .ovr(OVERRIDE)
  );

  // serial data pin drive
  assign SDIO_O = st_q.sdo;
  assign SDIO_OE = ~CSB_N & (st_q.ph == adc_regs_pkg::PH_DATA) & st_q.rd;

  // power modes steer the datapath; the serial port is never part of it
  assign DP_CLK_EN = (st_q.pm == adc_regs_pkg::PM_NORMAL);
  assign DP_RESET = (st_q.pm == adc_regs_pkg::PM_POWERDOWN) | (st_q.pm == adc_regs_pkg::PM_DIGRESET);
  assign OUT_EN = (st_q.pm == adc_regs_pkg::PM_NORMAL);

  // analog and output controls
  assign CHOP_EN = st_q.enh[adc_regs_pkg::B_CHOP];
  assign CLK_TERM = st_q.clk_adj[adc_regs_pkg::F_TERM +: 2];
  // a selected termination sets the current, so doubled drive is dropped
  assign CLK_DRIVE_2X = st_q.clk_adj[adc_regs_pkg::B_DRIVE] & (CLK_TERM == 2'h0);
  // phase delay only matters with the divider; the host keeps it within the ratio
  assign INPUT_PHASE = CLOCK_DIVIDER_ON ? st_q.oph[adc_regs_pkg::F_IPH +: 3] : 3'h0;
  assign DCO_PHASE = st_q.oph[3:0];
  assign SERIAL_CTL = st_q.ser;
  assign SDIO_PD_OFF = st_q.uio2[adc_regs_pkg::B_PD_OFF];
  assign CM_GEN_PD = st_q.uio3[adc_regs_pkg::B_CM_PD];

  AST_CH_SELECT: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_OMODE && !st_q.idx[0]) |=> ch_mode[0] == $past(ch_mode[0]))
    else $error("unselected channel took a per-channel write");

  AST_PM_NORMAL: assert property (@(posedge CLK) disable iff (!RESETN)
    (st_q.pm == adc_regs_pkg::PM_NORMAL) |-> (DP_CLK_EN && OUT_EN && !DP_RESET))
    else $error("normal mode does not run the datapath");

  AST_PM_DOWN: assert property (@(posedge CLK) disable iff (!RESETN)
    (st_q.pm == adc_regs_pkg::PM_POWERDOWN) |-> (!DP_CLK_EN && DP_RESET && !OUT_EN))
    else $error("power-down mode wrong");

  AST_PM_STANDBY: assert property (@(posedge CLK) disable iff (!RESETN)
    (st_q.pm == adc_regs_pkg::PM_STANDBY) |-> (!DP_CLK_EN && !DP_RESET && !OUT_EN))
    else $error("standby mode wrong");

  AST_PM_DIGRESET: assert property (@(posedge CLK) disable iff (!RESETN)
    (st_q.pm == adc_regs_pkg::PM_DIGRESET) |-> (DP_RESET && !OUT_EN))
    else $error("digital reset mode wrong");

  AST_PORT_ALIVE: assert property (@(posedge CLK) disable iff (!RESETN)
    (st_q.pm != adc_regs_pkg::PM_NORMAL && rise && st_q.ph == adc_regs_pkg::PH_INSTR
     && st_q.cnt != adc_regs_pkg::LAST_INSTR_BIT) |=> st_q.cnt == $past(st_q.cnt) + 4'h1)
    else $error("serial port stalled by power mode");

  AST_TERM_WINS: assert property (@(posedge CLK) disable iff (!RESETN)
    (CLK_TERM != 2'h0) |-> !CLK_DRIVE_2X)
    else $error("doubled drive applied with termination");

  AST_IPH_GATED: assert property (@(posedge CLK) disable iff (!RESETN)
    !CLOCK_DIVIDER_ON |-> INPUT_PHASE == 3'h0)
    else $error("input phase applied without divider");

  AST_DCO_RANGE: assert property (@(posedge CLK) disable iff (!RESETN)
    DCO_PHASE <= adc_regs_pkg::DCO_PH_MAX)
    else $error("data clock phase code out of range");

  // write effects show one cycle after the strobe; a wrong decode is caught here in the cycle the datapath already sees it
  AST_PM_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_PMODE) |=> st_q.pm == $past(wdata[1:0]))
    else $error("power mode write did not take effect");

  AST_IDX_MASKED: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_CHAN_IDX) |=> st_q.idx == ($past(wdata) & adc_regs_pkg::M_CHAN_IDX))
    else $error("channel index store wrong");

  AST_CHOP_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_ENH) |=> CHOP_EN == $past(wdata[adc_regs_pkg::B_CHOP]))
    else $error("chop enable does not follow its bit");

  AST_ENH_MASKED: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_ENH) |=> st_q.enh == ($past(wdata) & adc_regs_pkg::M_ENH))
    else $error("enhancement store kept open bits");

  AST_CLK_SLOT_KEPT: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_OADJ && st_q.idx[adc_regs_pkg::F_CLKSEL +: 2] == 2'h0)
    |=> $stable(st_q.clk_adj))
    else $error("clock slot written without clock channel selected");

  AST_OPH_INPUT: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_OPHASE) |=> st_q.oph[adc_regs_pkg::F_IPH +: 3] == $past(wdata[6:4]))
    else $error("input phase field not stored");

  AST_DCO_KEEP: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_OPHASE && wdata[3:0] > adc_regs_pkg::DCO_PH_MAX)
    |=> $stable(DCO_PHASE))
    else $error("undefined data clock phase code accepted");

  AST_SER_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_SERCTL) |=> SERIAL_CTL == $past(wdata))
    else $error("serial output control write did not take effect");

  AST_PD_OFF_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_UIO2) |=> SDIO_PD_OFF == $past(wdata[adc_regs_pkg::B_PD_OFF]))
    else $error("pull-down control does not follow its bit");

  AST_CM_PD_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_go && st_q.addr == adc_regs_pkg::A_UIO3) |=> CM_GEN_PD == $past(wdata[adc_regs_pkg::B_CM_PD]))
    else $error("common-mode power-down does not follow its bit");
endmodule // adc_ctrl_bank

// *** tb/spi_host.sv ***
// spi_host: host side of the serial control port, one single-byte frame at a time.
// assumes CLK is the 10 MHz bank clock; frame() is called only after reset release.
`timescale 1ns/100ps
module spi_host (
  // clock
  input wire logic clk,
  // device pins
  input wire logic sdio_o,
  input wire logic sdio_oe,
  output logic sclk,
  output logic csb_n,
  output logic sdio_i
);
  logic hbit;
  logic hoe;
  // wire level: device first, then host, else the pull-down wins
  assign sdio_i = sdio_oe ? sdio_o : (hoe ? hbit : 1'b0);
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    hbit = 1'b0;
    hoe = 1'b0;
  end
  // sclk 2 cycles high, 3 low: every edge is sampled even with slow output update
  task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] sh;
    sh = {rd, 2'b00, a, wd};
    rdat = 8'h00;
    @(posedge clk);
    #10 csb_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      #10 if (i >= 16) rdat[23-i] = sdio_i;
      hbit = sh[23-i];
      hoe = !(rd && i >= 16); // host lets go of the line in read data
      sclk = 1'b1;
      repeat (2) @(posedge clk);
      #10 sclk = 1'b0;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    #10 csb_n = 1'b1;
    hoe = 1'b0;
  endtask
endmodule // spi_host

// *** tb/adc_ctrl_bank_tb.sv ***
// adc_ctrl_bank_tb: directed register tests of the control bank over the serial port.
// assumes spi_host drives the port pins; no warm-up needed after reset.
`timescale 1ns/100ps
module adc_ctrl_bank_tb;
  logic CLK, RESETN, SCLK, CSB_N, SDIO_I, SDIO_O, SDIO_OE, CLOCK_DIVIDER_ON;
  logic DP_CLK_EN, DP_RESET, OUT_EN, CHOP_EN, CLK_DRIVE_2X, SDIO_PD_OFF, CM_GEN_PD;
  adc_regs_pkg::lane_cfg_t [1:0] LANE_CFG;
  adc_regs_pkg::ovr_t OVERRIDE;
  logic [1:0] CLK_TERM;
  logic [2:0] INPUT_PHASE;
  logic [3:0] DCO_PHASE;
  logic [7:0] SERIAL_CTL;
  int errors;
  int checks_done;
  logic [12:0] ra [0:10] = '{13'h005, 13'h008, 13'h00c, 13'h014, 13'h015, 13'h016, 13'h021, 13'h0ff, 13'h100,
    13'h101, 13'h102};
  logic [7:0] rv [0:10] = '{8'h33, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00};
  adc_ctrl_bank #(.NUM_CH(2)) uut (.CLK(CLK), .RESETN(RESETN), .SCLK(SCLK), .CSB_N(CSB_N), .SDIO_I(SDIO_I),
    .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE), .CLOCK_DIVIDER_ON(CLOCK_DIVIDER_ON), .DP_CLK_EN(DP_CLK_EN),
    .DP_RESET(DP_RESET), .OUT_EN(OUT_EN), .CHOP_EN(CHOP_EN), .LANE_CFG(LANE_CFG), .CLK_TERM(CLK_TERM),
    .CLK_DRIVE_2X(CLK_DRIVE_2X), .INPUT_PHASE(INPUT_PHASE), .DCO_PHASE(DCO_PHASE), .SERIAL_CTL(SERIAL_CTL),
    .OVERRIDE(OVERRIDE), .SDIO_PD_OFF(SDIO_PD_OFF), .CM_GEN_PD(CM_GEN_PD));
  spi_host host (.clk(CLK), .sdio_o(SDIO_O), .sdio_oe(SDIO_OE), .sclk(SCLK), .csb_n(CSB_N), .sdio_i(SDIO_I));
  // clock, 100 ns period
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.frame(1'b0, a, d, x);
  endtask
  task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] x;
    host.frame(1'b1, a, 8'h00, x);
    check($sformatf("reg %h", a), x, e);
  endtask
  // watchdog, well beyond the roughly 6000 cycles the tests take
  initial begin
    #3000000;
    errors++;
    give_verdict();
  end
  initial begin
    errors = 0;
    checks_done = 0;
    RESETN = 1'b0;
    CLOCK_DIVIDER_ON = 1'b0;
    repeat (3) @(posedge CLK);
    #10 check("lane0", 8'(LANE_CFG[0]), 8'h04);
    check("dco_phase", 8'(DCO_PHASE), 8'h03);
    check("serial_ctl", SERIAL_CTL, 8'h32);
    RESETN = 1'b1;
    for (int i = 0; i < 11; i++) rdchk(ra[i], rv[i]);
    // every power mode, open bits set; the port must keep answering in each
    for (int m = 0; m < 4; m++) begin
      wr(13'h008, 8'hfc | 8'(m));
      check("dp_clk_en", 8'(DP_CLK_EN), 8'(m == 0));
      check("dp_reset", 8'(DP_RESET), 8'(m == 1 || m == 3));
      check("out_en", 8'(OUT_EN), 8'(m == 0));
      rdchk(13'h008, 8'(m));
      rdchk(13'h021, 8'h32);
    end
    wr(13'h008, 8'h00);
    wr(13'h00c, 8'hff);
    check("chop_en", 8'(CHOP_EN), 8'h01);
    rdchk(13'h00c, 8'h04);
    wr(13'h005, 8'h01);
    wr(13'h014, 8'h44);
    check("lane0", 8'(LANE_CFG[0]), 8'h18);
    check("lane1", 8'(LANE_CFG[1]), 8'h04);
    wr(13'h005, 8'h02);
    wr(13'h015, 8'h30);
    check("lane1 term", 8'(LANE_CFG[1]), 8'h07);
    check("clk_term", 8'(CLK_TERM), 8'h00);
    // mode write with only channel 1 selected must leave channel 0 alone
    wr(13'h014, 8'h05);
    check("lane1 mode", 8'(LANE_CFG[1]), 8'h0f);
    check("lane0 kept", 8'(LANE_CFG[0]), 8'h18);
    // clock channel chosen first, then the drive bit
    wr(13'h005, 8'h10);
    wr(13'h015, 8'h01);
    check("drive", 8'(CLK_DRIVE_2X), 8'h01);
    wr(13'h015, 8'h21);
    check("drive vs term", 8'(CLK_DRIVE_2X), 8'h00);
    check("clk_term", 8'(CLK_TERM), 8'h02);
    // divider ratio taken as its largest value, so phase 7 stays legal
    CLOCK_DIVIDER_ON = 1'b1;
    wr(13'h016, 8'h7b);
    check("in_phase", 8'(INPUT_PHASE), 8'h07);
    check("dco_phase", 8'(DCO_PHASE), 8'h0b);
    wr(13'h016, 8'h2c);
    check("dco_phase kept", 8'(DCO_PHASE), 8'h0b);
    CLOCK_DIVIDER_ON = 1'b0;
    @(posedge CLK);
    #10 check("in_phase off", 8'(INPUT_PHASE), 8'h00);
    wr(13'h100, 8'he5);
    check("ovr pending", 8'(OVERRIDE), 8'h00);
    rdchk(13'h100, 8'h65);
    wr(13'h0ff, 8'hfe);
    check("ovr no commit", 8'(OVERRIDE), 8'h00);
    wr(13'h0ff, 8'h01);
    check("ovr applied", 8'(OVERRIDE), 8'h35);
    wr(13'h101, 8'hff);
    check("pd_off", 8'(SDIO_PD_OFF), 8'h01);
    rdchk(13'h101, 8'h01);
    wr(13'h102, 8'hff);
    check("cm_pd", 8'(CM_GEN_PD), 8'h01);
    rdchk(13'h102, 8'h08);
    wr(13'h021, 8'h22);
    check("serial_ctl", SERIAL_CTL, 8'h22);
    rdchk(13'h021, 8'h22);
    give_verdict();
  end
endmodule // adc_ctrl_bank_tb
